// *** modt_decoder.sv ***
// Opcode decode, cycle timing, condition flags and timer control setup.
`timescale 1ns/10ps
// Notes on behaviour
// - Some opcode positions are undefined and decode to no instruction.
// - Length and cycles follow the opcode column, bit test-and-branch 3/10, bit set/clear 2/7, relative branch 2/4.
// - Return from interrupt takes 9 cycles, return from subroutine 6, software interrupt 11, branch to subroutine 8.
// - Store accumulator and store index add one cycle, jump subtracts one, jump to subroutine adds three.
// - Half carry captures carry out of bit 3, and the register also holds mask, negative, zero and carry flags.
// - An affected flag is set when its condition holds and cleared otherwise, others keep their value unless the opcode forces them set or clear.
// - Return from interrupt reloads every flag from the stacked value.
// - The timer control bits can select the external clock divided by 128.
// - In the mask-programmed variant writes to timer control bits 0 to 5 have no effect.
module modt_decoder #(
    parameter int MASK_VARIANT = 0
) (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic OPCODE_VALID,
    input wire logic [7:0] OPCODE,
    input wire logic FLAG_UPDATE,
    input wire modt_pkg::modt_alu_s ALU,
    input wire logic [4:0] STACK_FLAGS,
    input wire logic TCTL_WRITE,
    input wire logic [5:0] TCTL_WDATA,
    output logic DECODE_VALID,
    output logic INSTR_UNDEFINED,
    output logic [1:0] INSTR_LENGTH,
    output logic [3:0] INSTR_CYCLES,
    output logic [4:0] FLAGS,
    output logic [5:0] TIMER_CTRL,
    output logic [7:0] TIMER_DIV_RATIO,
    output logic TIMER_EXT_CLK
);

    // ==========================================================
    // Elaboration check
    generate
        if (MASK_VARIANT < 0 || MASK_VARIANT > 1) begin : g_bad_variant
            $error("MASK_VARIANT must be 0 or 1");
        end
    endgenerate

    // ==========================================================
    // Functions
    function automatic logic half_carry(input logic [7:0] a, input logic [7:0] b,
                                        input logic [7:0] r);
        logic ha;
        logic hb;
        logic hr;
        ha = a[modt_pkg::HALF_CARRY_BIT];
        hb = b[modt_pkg::HALF_CARRY_BIT];
        hr = r[modt_pkg::HALF_CARRY_BIT];
        half_carry = (ha & hb) | (hb & ~hr) | (~hr & ha);
    endfunction : half_carry

    function automatic modt_pkg::modt_decode_s decode(input logic [7:0] op);
        modt_pkg::modt_decode_s d;
        logic [3:0] hi;
        logic [3:0] lo;
        hi = op[7:4];
        lo = op[3:0];
        d = '0;
        case (hi)
            4'h0: begin
                d.length = modt_pkg::LEN_3;
                d.cycles = modt_pkg::CYC_BIT_BRANCH;
                d.affect = modt_pkg::MASK_C;
            end
            4'h1: begin
                d.length = modt_pkg::LEN_2;
                d.cycles = modt_pkg::CYC_BIT_SETCLR;
            end
            4'h2: begin
                d.length = modt_pkg::LEN_2;
                d.cycles = modt_pkg::CYC_REL;
            end
            4'h3, 4'h4, 4'h5, 4'h6, 4'h7: begin
                case (hi)
                    4'h3: d.cycles = modt_pkg::CYC_RMW_DIR;
                    4'h6: d.cycles = modt_pkg::CYC_RMW_X1;
                    4'h7: d.cycles = modt_pkg::CYC_RMW_X0;
                    default: d.cycles = modt_pkg::CYC_RMW_ACC;
                endcase
                d.length = (hi == 4'h3 || hi == 4'h6) ? modt_pkg::LEN_2 : modt_pkg::LEN_1;
                case (lo)
                    4'h1, 4'h2, 4'h5, 4'hb, 4'he: d.undefined = 1'b1;
                    4'ha, 4'hc, 4'hd, 4'hf: d.affect = modt_pkg::MASK_NZ;
                    default: d.affect = modt_pkg::MASK_NZC;
                endcase
            end
            4'h8: begin
                d.length = modt_pkg::LEN_1;
                case (lo)
                    4'h0: begin
                        d.cycles = modt_pkg::CYC_RTI;
                        d.load_stack = 1'b1;
                    end
                    4'h1: d.cycles = modt_pkg::CYC_RTS;
                    4'h3: begin
                        d.cycles = modt_pkg::CYC_SWI;
                        d.force_set = modt_pkg::MASK_I;
                    end
                    default: d.undefined = 1'b1;
                endcase
            end
            4'h9: begin
                d.length = modt_pkg::LEN_1;
                d.cycles = modt_pkg::CYC_INH;
                case (lo)
                    4'h7, 4'hc, 4'hd, 4'hf: d.affect = modt_pkg::MASK_NONE;
                    4'h8: d.force_clr = modt_pkg::MASK_C;
                    4'h9: d.force_set = modt_pkg::MASK_C;
                    4'ha: d.force_clr = modt_pkg::MASK_I;
                    4'hb: d.force_set = modt_pkg::MASK_I;
                    default: d.undefined = 1'b1;
                endcase
            end
            default: begin
                case (hi)
                    4'ha: d.cycles = modt_pkg::CYC_IMM;
                    4'hb: d.cycles = modt_pkg::CYC_DIR;
                    4'hc: d.cycles = modt_pkg::CYC_EXT;
                    4'hd: d.cycles = modt_pkg::CYC_X2;
                    4'he: d.cycles = modt_pkg::CYC_X1;
                    default: d.cycles = modt_pkg::CYC_X0;
                endcase
                case (hi)
                    4'hc, 4'hd: d.length = modt_pkg::LEN_3;
                    4'hf: d.length = modt_pkg::LEN_1;
                    default: d.length = modt_pkg::LEN_2;
                endcase
                case (lo)
                    4'h0, 4'h1, 4'h2, 4'h3: d.affect = modt_pkg::MASK_NZC;
                    4'h9, 4'hb: d.affect = modt_pkg::MASK_HNZC;
                    4'hc, 4'hd: d.affect = modt_pkg::MASK_NONE;
                    default: d.affect = modt_pkg::MASK_NZ;
                endcase
                if (hi == 4'ha) begin
                    if (lo == 4'h7 || lo == 4'hc || lo == 4'hf) begin
                        d.undefined = 1'b1;
                    end else if (lo == 4'hd) begin
                        d.cycles = modt_pkg::CYC_BSR;
                    end
                end else if (lo == 4'h7 || lo == 4'hf) begin
                    d.cycles = d.cycles + modt_pkg::ADJ_STORE;
                end else if (lo == 4'hc) begin
                    d.cycles = d.cycles + modt_pkg::ADJ_JMP;
                end else if (lo == 4'hd) begin
                    d.cycles = d.cycles + modt_pkg::ADJ_JSR;
                end
            end
        endcase
        if (d.undefined) begin
            d.length = modt_pkg::LEN_1;
            d.cycles = modt_pkg::CYC_UNDEF;
            d.affect = modt_pkg::MASK_NONE;
            d.force_set = modt_pkg::MASK_NONE;
            d.force_clr = modt_pkg::MASK_NONE;
            d.load_stack = 1'b0;
        end
        decode = d;
    endfunction : decode

    // ==========================================================
    // Decode stage
    modt_pkg::modt_decode_s cur;
    modt_pkg::modt_decode_s next_cur;
    logic next_valid;

    always_comb begin
        next_cur = cur;
        next_valid = 1'b0;
        if (OPCODE_VALID) begin
            next_cur = decode(OPCODE);
            next_valid = 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            cur <= '0;
            DECODE_VALID <= 1'b0;
        end else begin
            cur <= next_cur;
            DECODE_VALID <= next_valid;
        end
    end

    assign INSTR_UNDEFINED = cur.undefined;
    assign INSTR_LENGTH = cur.length;
    assign INSTR_CYCLES = cur.cycles;

    // ==========================================================
    // Condition flags
    // Mask and forced bits come from the opcode already decoded, so the
    // datapath must pulse FLAG_UPDATE no earlier than DECODE_VALID.
    logic [4:0] next_flags;
    logic [4:0] tested;

    always_comb begin
        tested = '0;
        tested[modt_pkg::FLAG_H] = half_carry(ALU.operand_a, ALU.operand_b, ALU.result);
        tested[modt_pkg::FLAG_N] = ALU.result[7];
        tested[modt_pkg::FLAG_Z] = (ALU.result == 8'h00);
        tested[modt_pkg::FLAG_C] = ALU.carry;
        next_flags = FLAGS;
        if (FLAG_UPDATE) begin
            if (cur.load_stack) begin
                next_flags = STACK_FLAGS & modt_pkg::MASK_ALL;
            end else begin
                next_flags = (FLAGS & ~cur.affect) | (tested & cur.affect);
                next_flags = (next_flags | cur.force_set) & ~cur.force_clr;
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            FLAGS <= modt_pkg::FLAGS_RESET;
        end else begin
            FLAGS <= next_flags;
        end
    end

    // ==========================================================
    // Timer control setup
    // Software is expected to write these bits once right after reset; the
    // mask-programmed variant has no such bits, so the write is dropped there.
    logic [5:0] next_tctl;
    logic [7:0] next_ratio;

    always_comb begin
        next_tctl = TIMER_CTRL;
        if (TCTL_WRITE && MASK_VARIANT == 0) begin
            next_tctl = TCTL_WDATA;
        end
        next_ratio = 8'h01 << next_tctl[modt_pkg::TCTL_DIV_LSB +: 3];
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            TIMER_CTRL <= modt_pkg::TCTL_RESET;
            TIMER_DIV_RATIO <= 8'h01;
            TIMER_EXT_CLK <= 1'b0;
        end else begin
            TIMER_CTRL <= next_tctl;
            TIMER_DIV_RATIO <= next_ratio;
            TIMER_EXT_CLK <= next_tctl[modt_pkg::TCTL_SRC_BIT];
        end
    end

endmodule : modt_decoder

// *** modt_pkg.sv ***
// Package: constants and carrier types for the opcode decode and timing block.
package modt_pkg;

    // ==========================================================
    // Condition flag positions
    localparam int FLAG_H = 4;
    localparam int FLAG_I = 3;
    localparam int FLAG_N = 2;
    localparam int FLAG_Z = 1;
    localparam int FLAG_C = 0;
    localparam logic [4:0] FLAGS_RESET = 5'h08;
    localparam logic [4:0] MASK_NONE = 5'h00;
    localparam logic [4:0] MASK_NZ = 5'h06;
    localparam logic [4:0] MASK_NZC = 5'h07;
    localparam logic [4:0] MASK_HNZC = 5'h17;
    localparam logic [4:0] MASK_C = 5'h01;
    localparam logic [4:0] MASK_I = 5'h08;
    localparam logic [4:0] MASK_ALL = 5'h1f;
    localparam int HALF_CARRY_BIT = 3;

    // ==========================================================
    // Lengths and cycle counts
    localparam logic [1:0] LEN_1 = 2'h1;
    localparam logic [1:0] LEN_2 = 2'h2;
    localparam logic [1:0] LEN_3 = 2'h3;
    localparam logic [3:0] CYC_BIT_BRANCH = 4'ha;
    localparam logic [3:0] CYC_BIT_SETCLR = 4'h7;
    localparam logic [3:0] CYC_REL = 4'h4;
    localparam logic [3:0] CYC_RMW_DIR = 4'h6;
    localparam logic [3:0] CYC_RMW_ACC = 4'h4;
    localparam logic [3:0] CYC_RMW_X1 = 4'h7;
    localparam logic [3:0] CYC_RMW_X0 = 4'h6;
    localparam logic [3:0] CYC_INH = 4'h2;
    localparam logic [3:0] CYC_IMM = 4'h2;
    localparam logic [3:0] CYC_DIR = 4'h4;
    localparam logic [3:0] CYC_EXT = 4'h5;
    localparam logic [3:0] CYC_X2 = 4'h6;
    localparam logic [3:0] CYC_X1 = 4'h5;
    localparam logic [3:0] CYC_X0 = 4'h4;
    localparam logic [3:0] CYC_RTI = 4'h9;
    localparam logic [3:0] CYC_RTS = 4'h6;
    localparam logic [3:0] CYC_SWI = 4'hb;
    localparam logic [3:0] CYC_BSR = 4'h8;
    localparam logic [3:0] CYC_UNDEF = 4'h2;
    localparam logic [3:0] ADJ_STORE = 4'h1;
    localparam logic [3:0] ADJ_JMP = 4'hf;
    localparam logic [3:0] ADJ_JSR = 4'h3;

    // ==========================================================
    // Timer control layout
    localparam int TCTL_WIDTH = 6;
    localparam int TCTL_DIV_LSB = 0;
    localparam int TCTL_SRC_BIT = 5;
    localparam logic [5:0] TCTL_RESET = 6'h00;

    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic undefined;
        logic [1:0] length;
        logic [3:0] cycles;
        logic [4:0] affect;
        logic [4:0] force_set;
        logic [4:0] force_clr;
        logic load_stack;
    } modt_decode_s;

    typedef struct packed {
        logic [7:0] operand_a;
        logic [7:0] operand_b;
        logic [7:0] result;
        logic carry;
    } modt_alu_s;

endpackage : modt_pkg

// *** modt_checker.sv ***
// Concurrent checks on the ports of the opcode decode and timing block.
`timescale 1ns/10ps
module modt_checker #(
    parameter int MASK_VARIANT = 0
) (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic OPCODE_VALID,
    input wire logic [7:0] OPCODE,
    input wire logic FLAG_UPDATE,
    input wire modt_pkg::modt_alu_s ALU,
    input wire logic [4:0] STACK_FLAGS,
    input wire logic TCTL_WRITE,
    input wire logic [5:0] TCTL_WDATA,
    input wire logic DECODE_VALID,
    input wire logic INSTR_UNDEFINED,
    input wire logic [1:0] INSTR_LENGTH,
    input wire logic [3:0] INSTR_CYCLES,
    input wire logic [4:0] FLAGS,
    input wire logic [5:0] TIMER_CTRL,
    input wire logic [7:0] TIMER_DIV_RATIO,
    input wire logic TIMER_EXT_CLK
);
    // ==========================================================
    // Helper state
    // Flags apply to the last completed decode, so its opcode is kept here.
    logic [7:0] last_op;
    logic [7:0] next_last_op;
    logic hc;
    always_comb begin
        next_last_op = !RST_N ? 8'h00 : (OPCODE_VALID ? OPCODE : last_op);
    end
    always_ff @(posedge CLK_SYS) begin
        last_op <= next_last_op;
    end
    assign hc = ALU.operand_a[4] ^ ALU.operand_b[4] ^ ALU.result[4];
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    // ==========================================================
    // Assertions
    dv_answer_a: assert property (OPCODE_VALID |=> DECODE_VALID)
        else $error("decode not answered");
    dv_stray_a: assert property (!OPCODE_VALID |=> !DECODE_VALID)
        else $error("stray decode valid");
    bit_branch_a: assert property (OPCODE_VALID && OPCODE[7:4] == 4'h0 |=>
        INSTR_LENGTH == 2'h3 && INSTR_CYCLES == 4'ha) else $error("bit branch timing");
    rel_branch_a: assert property (OPCODE_VALID && OPCODE[7:4] == 4'h2 |=>
        INSTR_LENGTH == 2'h2 && INSTR_CYCLES == 4'h4) else $error("branch timing");
    swi_cycles_a: assert property (OPCODE_VALID && OPCODE == 8'h83 |=> INSTR_CYCLES == 4'hb)
        else $error("software interrupt cycles");
    store_adj_a: assert property (OPCODE_VALID && OPCODE == 8'hb7 |=> INSTR_CYCLES == 4'h5)
        else $error("store adjustment");
    undef_len_a: assert property (DECODE_VALID && INSTR_UNDEFINED |-> INSTR_LENGTH == 2'h1)
        else $error("undefined length");
    flags_hold_a: assert property (!FLAG_UPDATE |=> $stable(FLAGS))
        else $error("flags moved without update");
    undef_flags_a: assert property (FLAG_UPDATE && INSTR_UNDEFINED |=> $stable(FLAGS))
        else $error("undefined opcode changed flags");
    rti_load_a: assert property (FLAG_UPDATE && last_op == 8'h80 |=> FLAGS == $past(STACK_FLAGS))
        else $error("stacked flags not loaded");
    half_carry_a: assert property (FLAG_UPDATE && last_op == 8'hab |=>
        FLAGS[modt_pkg::FLAG_H] == $past(hc)) else $error("half carry wrong");
    tdiv_map_a: assert property (TIMER_DIV_RATIO == (8'h01 << TIMER_CTRL[2:0])
        && TIMER_EXT_CLK == TIMER_CTRL[5]) else $error("timer ratio or source wrong");
    tctl_write_a: assert property (TCTL_WRITE && MASK_VARIANT == 0 |=>
        TIMER_CTRL == $past(TCTL_WDATA)) else $error("timer control not written");
    mask_ignore_a: assert property (MASK_VARIANT != 0 |-> TIMER_CTRL == 6'h00)
        else $error("masked variant took a write");
    cover property (FLAG_UPDATE && last_op == 8'h80);
    cover property (TCTL_WRITE && TCTL_WDATA == 6'h27);
    cover property (DECODE_VALID && INSTR_UNDEFINED);
endmodule : modt_checker

bind modt_decoder modt_checker #(.MASK_VARIANT(MASK_VARIANT)) i_modt_checker (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .OPCODE_VALID(OPCODE_VALID), .OPCODE(OPCODE),
    .FLAG_UPDATE(FLAG_UPDATE), .ALU(ALU), .STACK_FLAGS(STACK_FLAGS), .TCTL_WRITE(TCTL_WRITE),
    .TCTL_WDATA(TCTL_WDATA), .DECODE_VALID(DECODE_VALID), .INSTR_UNDEFINED(INSTR_UNDEFINED),
    .INSTR_LENGTH(INSTR_LENGTH), .INSTR_CYCLES(INSTR_CYCLES), .FLAGS(FLAGS),
    .TIMER_CTRL(TIMER_CTRL), .TIMER_DIV_RATIO(TIMER_DIV_RATIO), .TIMER_EXT_CLK(TIMER_EXT_CLK));

// *** testbench.sv ***
// Self-checking bench for the opcode decode and timing block.
`timescale 1ns/10ps
module testbench;
    // ==========================================================
    // Signals
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic op_vld = 1'b0;
    logic [7:0] op = 8'h00;
    logic flag_upd = 1'b0;
    modt_pkg::modt_alu_s alu = 25'h0;
    modt_pkg::modt_alu_s a = 25'h0;
    logic [4:0] stk = 5'h00;
    logic tc_wr = 1'b0;
    logic [5:0] tc_wd = 6'h00;
    logic dv, undef, ext, m_ext, pend;
    logic [1:0] len;
    logic [3:0] cyc;
    logic [4:0] flags, mf;
    logic [5:0] tctl, m_tctl;
    logic [7:0] ratio, m_ratio, pop;
    logic [7:0] fops [8] = '{8'h99, 8'h98, 8'h9a, 8'h83, 8'h9a, 8'h9b, 8'h97, 8'h31};
    int error_cnt = 0;
    int samples_checked = 0;
    localparam logic [1:0] LEN_T [16] = '{2'h3, 2'h2, 2'h2, 2'h2, 2'h1, 2'h1, 2'h2, 2'h1,
        2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h2, 2'h1};
    localparam logic [3:0] CYC_T [16] = '{4'ha, 4'h7, 4'h4, 4'h6, 4'h4, 4'h4, 4'h7, 4'h6,
        4'h0, 4'h2, 4'h2, 4'h4, 4'h5, 4'h6, 4'h5, 4'h4};

    modt_decoder #(.MASK_VARIANT(0)) i_modt_decoder (.CLK_SYS(clk), .RST_N(rst_n),
        .OPCODE_VALID(op_vld), .OPCODE(op), .FLAG_UPDATE(flag_upd), .ALU(alu), .STACK_FLAGS(stk),
        .TCTL_WRITE(tc_wr), .TCTL_WDATA(tc_wd), .DECODE_VALID(dv), .INSTR_UNDEFINED(undef),
        .INSTR_LENGTH(len), .INSTR_CYCLES(cyc), .FLAGS(flags), .TIMER_CTRL(tctl),
        .TIMER_DIV_RATIO(ratio), .TIMER_EXT_CLK(ext));
    // The masked variant sees the same writes and must ignore every one.
    modt_decoder #(.MASK_VARIANT(1)) i_modt_decoder_mask (.CLK_SYS(clk), .RST_N(rst_n),
        .OPCODE_VALID(op_vld), .OPCODE(op), .FLAG_UPDATE(flag_upd), .ALU(alu), .STACK_FLAGS(stk),
        .TCTL_WRITE(tc_wr), .TCTL_WDATA(tc_wd), .DECODE_VALID(), .INSTR_UNDEFINED(),
        .INSTR_LENGTH(), .INSTR_CYCLES(), .FLAGS(), .TIMER_CTRL(m_tctl),
        .TIMER_DIV_RATIO(m_ratio), .TIMER_EXT_CLK(m_ext));

    initial begin
        forever #20 clk = ~clk;
    end

    // ==========================================================
    // Expectations and drivers
    function automatic logic is_undef(input logic [7:0] o);
        if (o[7:4] >= 4'h3 && o[7:4] <= 4'h7) return o[3:0] inside {4'h1, 4'h2, 4'h5, 4'hb, 4'he};
        if (o[7:4] == 4'h8) return !(o[3:0] inside {4'h0, 4'h1, 4'h3});
        if (o[7:4] == 4'h9) return o[3:0] <= 4'h6 || o[3:0] == 4'he;
        if (o[7:4] == 4'ha) return o[3:0] inside {4'h7, 4'hc, 4'hf};
        return 1'b0;
    endfunction : is_undef

    function automatic logic [5:0] timing(input logic [7:0] o);
        logic [3:0] c;
        c = CYC_T[o[7:4]];
        if (is_undef(o)) return {2'h1, 4'h2};
        if (o == 8'h80) c = 4'h9;
        if (o == 8'h81) c = 4'h6;
        if (o == 8'h83) c = 4'hb;
        if (o == 8'had) c = 4'h8;
        if (o[7:4] >= 4'hb && (o[3:0] == 4'h7 || o[3:0] == 4'hf)) c = c + 4'h1;
        if (o[7:4] >= 4'hb && o[3:0] == 4'hc) c = c - 4'h1;
        if (o[7:4] >= 4'hb && o[3:0] == 4'hd) c = c + 4'h3;
        return {LEN_T[o[7:4]], c};
    endfunction : timing

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic dec(input logic [7:0] o, input logic v);
        logic [5:0] t;
        @(negedge clk);
        t = timing(pop);
        chk("valid", 8'(pend), 8'(dv));
        if (pend) begin
            chk("undefined", 8'(is_undef(pop)), 8'(undef));
            chk("length", 8'(t[5:4]), 8'(len));
            chk("cycles", 8'(t[3:0]), 8'(cyc));
        end
        pend = v;
        pop = o;
        op_vld = v;
        op = o;
    endtask : dec

    task automatic fop(input logic [7:0] o, input logic [4:0] s);
        dec(o, 1'b1);
        dec(o, 1'b0);
        flag_upd = 1'b1;
        alu = a;
        stk = s;
        @(negedge clk);
        flag_upd = 1'b0;
        chk("flags", 8'(mf), 8'(flags));
    endtask : fop

    task automatic twr(input logic [5:0] d);
        @(negedge clk);
        tc_wr = 1'b1;
        tc_wd = d;
        @(negedge clk);
        tc_wr = 1'b0;
        chk("timer_ctrl", 8'(d), 8'(tctl));
        chk("div_ratio", 8'h01 << d[2:0], ratio);
        chk("ext_clk", 8'(d[5]), 8'(ext));
        chk("mask_ctrl", 8'h00, 8'(m_tctl));
        chk("mask_ratio", 8'h01, m_ratio);
        chk("mask_ext", 8'h00, 8'(m_ext));
    endtask : twr

    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        results();
    end

    // ==========================================================
    // Main sequence
    initial begin
        pend = 1'b0;
        pop = 8'h00;
        mf = 5'h08;
        void'($urandom(32'h3aa85984));
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        chk("reset_flags", 8'h08, 8'(flags));
        for (int i = 0; i < 256; i++) dec(8'(i), 1'b1);
        repeat (64) dec(8'($urandom), 1'b1);
        for (int i = 0; i < 24; i++) begin
            a.operand_a = i == 0 ? 8'h08 : (i == 1 ? 8'h80 : 8'($urandom));
            a.operand_b = i == 0 ? 8'h08 : (i == 1 ? 8'h80 : 8'($urandom));
            {a.carry, a.result} = {1'b0, a.operand_a} + {1'b0, a.operand_b};
            mf = {a.operand_a[4] ^ a.operand_b[4] ^ a.result[4], mf[3], a.result[7],
                a.result == 8'h00, a.carry};
            fop(8'hab, 5'h00);
        end
        foreach (fops[k]) begin
            case (fops[k])
                8'h99: mf[0] = 1'b1;
                8'h98: mf[0] = 1'b0;
                8'h9a: mf[3] = 1'b0;
                8'h97, 8'h31: mf = mf;
                default: mf[3] = 1'b1;
            endcase
            fop(fops[k], 5'($urandom));
        end
        repeat (4) begin
            stk = 5'($urandom);
            mf = stk;
            fop(8'h80, stk);
        end
        for (int i = 0; i < 20; i++) twr(i == 0 ? 6'h27 : 6'($urandom));
        rst_n = 1'b0;
        @(negedge clk);
        rst_n = 1'b1;
        chk("rerun_flags", 8'h08, 8'(flags));
        chk("rerun_ctrl", 8'h00, 8'(tctl));
        twr(6'h27);
        results();
    end
endmodule : testbench
